// ==== shared/irc_pkg.sv ====
// Constants, register map and carrier types for the window cropping stage.
// Assumes a 32-bit APB register bus and a single 125 MHz clock domain.
`default_nettype none
package irc_pkg;
  localparam int unsigned DIM_W        = 17;
  localparam int unsigned PIX_W        = 16;
  localparam int unsigned ADDR_W       = 8;

  localparam logic [DIM_W-1:0] COLS_MIN     = 17'h0_0040;
  localparam logic [DIM_W-1:0] COLS_MAX     = 17'h0_8000;
  localparam logic [DIM_W-1:0] COLS_STEP_M  = 17'h0_001F;
  localparam logic [DIM_W-1:0] ROWS_MIN     = 17'h0_0002;
  localparam logic [DIM_W-1:0] ROWS_MAX     = 17'h1_0000;
  localparam logic [DIM_W-1:0] XSTART_MAX   = 17'h0_7FC0;
  localparam logic [DIM_W-1:0] YSTART_MAX   = 17'h0_FFFF;
  localparam logic [DIM_W-1:0] COLS_RST     = 17'h0_0400;
  localparam logic [DIM_W-1:0] ROWS_RST     = 17'h0_0400;
  localparam logic [DIM_W-1:0] START_RST    = 17'h0_0000;
  localparam logic [63:0]      DRAM_PIX_DEF = 64'h0000_0000_1000_0000;

  localparam logic [ADDR_W-1:0] A_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] A_COLS      = 8'h04;
  localparam logic [ADDR_W-1:0] A_ROWS      = 8'h08;
  localparam logic [ADDR_W-1:0] A_XSTART    = 8'h0C;
  localparam logic [ADDR_W-1:0] A_YSTART    = 8'h10;
  localparam logic [ADDR_W-1:0] A_FF_COLS   = 8'h14;
  localparam logic [ADDR_W-1:0] A_FF_ROWS   = 8'h18;
  localparam logic [ADDR_W-1:0] A_STATUS    = 8'h1C;
  localparam logic [ADDR_W-1:0] A_BUF_COLS  = 8'h20;
  localparam logic [ADDR_W-1:0] A_BUF_ROWS  = 8'h24;

  localparam int unsigned B_RUN    = 0;
  localparam int unsigned B_HMIR   = 1;
  localparam int unsigned B_VMIR   = 2;
  localparam int unsigned B_FOLLOW = 3;
  localparam int unsigned B_REJECT = 0;
  localparam int unsigned B_ACTIVE = 1;

  typedef struct packed {
    logic [DIM_W-1:0] cols;
    logic [DIM_W-1:0] rows;
    logic [DIM_W-1:0] horizontal_crop_start;
    logic [DIM_W-1:0] vertical_crop_start;
    logic [DIM_W-1:0] full_frame_columns;
    logic [DIM_W-1:0] full_frame_rows;
    logic             hmirror;
    logic             vmirror;
    logic             run;
    logic             auto_window_follow;
  } irc_cfg_t;

  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic             sof;
    logic             eol;
  } irc_pix_t;

  typedef enum logic [0:0] {
    ST_PASS = 1'b0,
    ST_PAD  = 1'b1
  } irc_state_t;
endpackage
`default_nettype wire

// ==== design/irc_limits.sv ====
// Combinational check of a candidate window setting against all limits.
// Assumes the candidate is assembled by the register file.
`default_nettype none
module irc_limits
  import irc_pkg::*;
#(
  parameter logic [63:0] DRAM_PIXELS = DRAM_PIX_DEF
) (
  input  wire irc_cfg_t i_cfg,
  output logic          o_ok
);
  logic [DIM_W:0]   x_end;
  logic [DIM_W:0]   y_end;
  logic [DIM_W:0]   x_lim;
  logic [DIM_W:0]   y_lim;
  logic [2*DIM_W:0] frame_px;
  logic             cols_ok;
  logic             rows_ok;
  logic             xs_ok;
  logic             ys_ok;
  logic             sens_ok;
  logic             dram_ok;

  always_comb begin
    cols_ok = (i_cfg.cols >= COLS_MIN) && (i_cfg.cols <= COLS_MAX)
              && ((i_cfg.cols & COLS_STEP_M) == '0);
    rows_ok = (i_cfg.rows >= ROWS_MIN) && (i_cfg.rows <= ROWS_MAX);
    xs_ok   = (i_cfg.horizontal_crop_start <= XSTART_MAX)
              && ((i_cfg.horizontal_crop_start & COLS_STEP_M) == '0);
    ys_ok   = i_cfg.vertical_crop_start <= YSTART_MAX;
    sens_ok = (i_cfg.full_frame_columns >= COLS_MIN) && (i_cfg.full_frame_columns <= COLS_MAX)
              && ((i_cfg.full_frame_columns & COLS_STEP_M) == '0)
              && (i_cfg.full_frame_rows >= ROWS_MIN) && (i_cfg.full_frame_rows <= ROWS_MAX);
    x_end   = {1'b0, i_cfg.cols} + {1'b0, i_cfg.horizontal_crop_start};
    y_end   = {1'b0, i_cfg.rows} + {1'b0, i_cfg.vertical_crop_start};
    x_lim   = i_cfg.hmirror ? {1'b0, i_cfg.full_frame_columns} : {1'b0, COLS_MAX};
    y_lim   = i_cfg.vmirror ? {1'b0, i_cfg.full_frame_rows} : {1'b0, ROWS_MAX};
    // Double buffering needs room for two whole sensor frames.
    frame_px = {i_cfg.full_frame_columns, 1'b0} * {1'b0, i_cfg.full_frame_rows};
    dram_ok  = !i_cfg.vmirror || ({29'h0, frame_px} <= DRAM_PIXELS);
    o_ok     = cols_ok && rows_ok && xs_ok && ys_ok && sens_ok
               && (x_end <= x_lim) && (y_end <= y_lim) && dram_ok;
  end
endmodule
`default_nettype wire

// ==== design/irc_crop.sv ====
// Window cropping stage with its APB register file.
// Assumes the downstream DMA path takes one pixel on every cycle that o_valid is high.
//
// Functional notes
// - Width 64 to 32768 columns, multiple of 32, reset value 1024.
// - Height 2 to 65536 rows, any step, reset value 1024.
// - Horizontal start 0 to 32704, multiple of 32, reset value zero.
// - Vertical start 0 to 65535, reset value zero.
// - Width plus horizontal start never beyond 32768 columns.
// - Height plus vertical start never beyond 65536 rows.
// - With horizontal mirroring, width plus start is limited by sensor columns.
// - With vertical mirroring, height plus start is limited by sensor rows.
// - With vertical mirroring, two sensor frames must fit into the DRAM.
// - Output frame size follows window size and is reported to the host.
// - Short camera lines are padded to full window width; rows may be cut.
// - Window settings change only while acquisition is stopped; after run is cleared, writes are taken while the last window row is padded.
//
// Our own choices: register access over APB and the register offsets.
`default_nettype none
module irc_crop
  import irc_pkg::*;
#(
  parameter logic [63:0] DRAM_PIXELS = DRAM_PIX_DEF
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire irc_pix_t          i_pix,
  input  wire logic              i_valid,
  output logic                   o_ready,
  output irc_pix_t               o_pix,
  output logic                   o_valid,
  output logic      [DIM_W-1:0]  o_buf_cols,
  output logic      [DIM_W-1:0]  o_buf_rows,
  output logic                   o_auto_window_follow
);
  // A zero DRAM size would leave no vertically mirrored setting that could ever be accepted.
  if (DRAM_PIXELS == 64'h0) begin : g_dram_check
    $error("DRAM_PIXELS must be non-zero");
  end

  irc_cfg_t         cfg_ff;
  irc_cfg_t         cand;
  logic             cand_ok;
  logic             reject_ff;
  logic             live_ff;
  logic             pend_sof_ff;
  irc_state_t       state_ff;
  logic [DIM_W-1:0] col_ff;
  logic [DIM_W:0]   row_ff;
  logic [DIM_W-1:0] ecnt_ff;
  logic [31:0]      rd_ff;
  irc_pix_t         opix_ff;
  logic             ovalid_ff;

  logic             wr_acc;
  logic             mapped;
  logic             cfg_wr;
  logic             busy;
  logic             wr_bad;
  logic [31:0]      rd_mux;

  irc_limits #(
    .DRAM_PIXELS(DRAM_PIXELS)
  ) u_limits (
    .i_cfg(cand),
    .o_ok (cand_ok)
  );

  // Register bus decode; zero wait states, so pready stays high.
  assign pready = 1'b1;
  assign busy   = cfg_ff.run || live_ff;

  always_comb begin
    mapped = 1'b1;
    cfg_wr = 1'b1;
    cand   = cfg_ff;
    case (paddr)
      A_CTRL: begin
        cand.run                = pwdata[B_RUN];
        cand.hmirror            = pwdata[B_HMIR];
        cand.vmirror            = pwdata[B_VMIR];
        cand.auto_window_follow = pwdata[B_FOLLOW];
      end
      A_COLS:     cand.cols                  = pwdata[DIM_W-1:0];
      A_ROWS:     cand.rows                  = pwdata[DIM_W-1:0];
      A_XSTART:   cand.horizontal_crop_start = pwdata[DIM_W-1:0];
      A_YSTART:   cand.vertical_crop_start   = pwdata[DIM_W-1:0];
      A_FF_COLS:  cand.full_frame_columns    = pwdata[DIM_W-1:0];
      A_FF_ROWS:  cand.full_frame_rows       = pwdata[DIM_W-1:0];
      A_STATUS:   cfg_wr = 1'b0;
      A_BUF_COLS: cfg_wr = 1'b0;
      A_BUF_ROWS: cfg_wr = 1'b0;
      default: begin
        mapped = 1'b0;
        cfg_wr = 1'b0;
      end
    endcase
  end

  always_comb begin
    wr_acc = psel && penable && pwrite;
    wr_bad = 1'b0;
    if (cfg_wr) begin
      if (!cand_ok) begin
        wr_bad = 1'b1;
      end
      // While running only the run and follow bits may move.
      if (busy && (paddr != A_CTRL || cand.hmirror != cfg_ff.hmirror
                   || cand.vmirror != cfg_ff.vmirror)) begin
        wr_bad = 1'b1;
      end
    end
    pslverr = psel && penable && (!mapped || (pwrite && wr_bad));
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_ff.cols                  <= COLS_RST;
      cfg_ff.rows                  <= ROWS_RST;
      cfg_ff.horizontal_crop_start <= START_RST;
      cfg_ff.vertical_crop_start   <= START_RST;
      cfg_ff.full_frame_columns    <= COLS_RST;
      cfg_ff.full_frame_rows       <= ROWS_RST;
      cfg_ff.hmirror               <= 1'b0;
      cfg_ff.vmirror               <= 1'b0;
      cfg_ff.run                   <= 1'b0;
      cfg_ff.auto_window_follow    <= 1'b0;
    end else if (wr_acc && cfg_wr && !wr_bad) begin
      cfg_ff <= cand;
    end
  end

  // Sticky rejection flag, write one to clear; a new rejection beats the clear.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      reject_ff <= 1'b0;
    end else if (wr_acc && mapped && wr_bad) begin
      reject_ff <= 1'b1;
    end else if (wr_acc && paddr == A_STATUS && pwdata[B_REJECT]) begin
      reject_ff <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      A_CTRL: begin
        rd_mux[B_RUN]    = cfg_ff.run;
        rd_mux[B_HMIR]   = cfg_ff.hmirror;
        rd_mux[B_VMIR]   = cfg_ff.vmirror;
        rd_mux[B_FOLLOW] = cfg_ff.auto_window_follow;
      end
      A_COLS:     rd_mux[DIM_W-1:0] = cfg_ff.cols;
      A_ROWS:     rd_mux[DIM_W-1:0] = cfg_ff.rows;
      A_XSTART:   rd_mux[DIM_W-1:0] = cfg_ff.horizontal_crop_start;
      A_YSTART:   rd_mux[DIM_W-1:0] = cfg_ff.vertical_crop_start;
      A_FF_COLS:  rd_mux[DIM_W-1:0] = cfg_ff.full_frame_columns;
      A_FF_ROWS:  rd_mux[DIM_W-1:0] = cfg_ff.full_frame_rows;
      A_STATUS: begin
        rd_mux[B_REJECT] = reject_ff;
        rd_mux[B_ACTIVE] = live_ff;
      end
      A_BUF_COLS: rd_mux[DIM_W-1:0] = o_buf_cols;
      A_BUF_ROWS: rd_mux[DIM_W-1:0] = o_buf_rows;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup phase so it is a flip-flop in the access phase.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_ff <= 32'h0000_0000;
    end else if (psel && !penable) begin
      rd_ff <= rd_mux;
    end
  end
  assign prdata = rd_ff;

  assign o_buf_cols           = cfg_ff.cols;
  assign o_buf_rows           = cfg_ff.rows[DIM_W-1:0];
  assign o_auto_window_follow = cfg_ff.auto_window_follow;

  // Pixel path.
  logic             acc;
  logic [DIM_W-1:0] cur_col;
  logic [DIM_W:0]   cur_row;
  logic [DIM_W-1:0] cur_ecnt;
  logic [DIM_W-1:0] ecnt_inc;
  logic             live;
  logic             row_in;
  logic             in_win;
  logic [DIM_W:0]   x_end;
  logic [DIM_W:0]   y_end;

  assign o_ready = (state_ff == ST_PASS);
  assign acc     = i_valid && o_ready;

  always_comb begin
    x_end    = {1'b0, cfg_ff.cols} + {1'b0, cfg_ff.horizontal_crop_start};
    y_end    = {1'b0, cfg_ff.rows} + {1'b0, cfg_ff.vertical_crop_start};
    cur_col  = i_pix.sof ? '0 : col_ff;
    cur_row  = i_pix.sof ? '0 : row_ff;
    cur_ecnt = i_pix.sof ? '0 : ecnt_ff;
    live     = i_pix.sof ? cfg_ff.run : live_ff;
    row_in   = live && (cur_row >= {1'b0, cfg_ff.vertical_crop_start}) && (cur_row < y_end);
    in_win   = row_in && ({1'b0, cur_col} >= {1'b0, cfg_ff.horizontal_crop_start})
               && ({1'b0, cur_col} < x_end) && (cur_ecnt < cfg_ff.cols);
    ecnt_inc = cur_ecnt + {{(DIM_W-1){1'b0}}, in_win};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      col_ff <= '0;
      row_ff <= '0;
    end else if (acc) begin
      if (i_pix.eol) begin
        col_ff <= '0;
        row_ff <= (cur_row == '1) ? cur_row : cur_row + 1'b1;
      end else begin
        // Oversized lines saturate instead of wrapping back into the window.
        col_ff <= (cur_col == '1) ? cur_col : cur_col + 1'b1;
        row_ff <= cur_row;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      live_ff <= 1'b0;
    end else if (acc) begin
      if (i_pix.eol && !cfg_ff.run && (cur_row + 1'b1 >= y_end)) begin
        live_ff <= 1'b0;
      end else begin
        live_ff <= live;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= ST_PASS;
      ecnt_ff  <= '0;
    end else begin
      case (state_ff)
        ST_PASS: begin
          if (acc) begin
            if (i_pix.eol && row_in && ecnt_inc < cfg_ff.cols) begin
              state_ff <= ST_PAD;
              ecnt_ff  <= ecnt_inc;
            end else if (i_pix.eol) begin
              ecnt_ff <= '0;
            end else begin
              ecnt_ff <= ecnt_inc;
            end
          end
        end
        ST_PAD: begin
          if (ecnt_ff + 1'b1 == cfg_ff.cols) begin
            state_ff <= ST_PASS;
            ecnt_ff  <= '0;
          end else begin
            ecnt_ff <= ecnt_ff + 1'b1;
          end
        end
        default: begin
          state_ff <= ST_PASS;
          ecnt_ff  <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend_sof_ff <= 1'b0;
    end else if (acc && i_pix.sof && !in_win) begin
      pend_sof_ff <= cfg_ff.run;
    end else if ((acc && in_win) || state_ff == ST_PAD) begin
      pend_sof_ff <= 1'b0;
    end
  end

  // Padding pixels carry zero; their content is undefined for the consumer.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ovalid_ff <= 1'b0;
      opix_ff   <= '0;
    end else if (state_ff == ST_PAD) begin
      ovalid_ff    <= 1'b1;
      opix_ff.data <= '0;
      opix_ff.sof  <= pend_sof_ff;
      opix_ff.eol  <= (ecnt_ff + 1'b1 == cfg_ff.cols);
    end else begin
      ovalid_ff    <= acc && in_win;
      opix_ff.data <= i_pix.data;
      opix_ff.sof  <= acc && in_win && (i_pix.sof || pend_sof_ff);
      opix_ff.eol  <= acc && in_win && (ecnt_inc == cfg_ff.cols);
    end
  end

  assign o_valid = ovalid_ff;
  assign o_pix   = opix_ff;
endmodule
`default_nettype wire

// ==== verif/irc_crop_monitor.sv ====
// Checker for the window cropping stage.
// Assumes it sees only the ports of irc_crop.
`default_nettype none
module irc_crop_monitor
  import irc_pkg::*;
#(
  parameter logic [63:0] DRAM_PIXELS = DRAM_PIX_DEF
) (
  input wire logic             i_clk,
  input wire logic             i_rst,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire irc_pix_t         i_pix,
  input wire logic             i_valid,
  input wire logic             o_ready,
  input wire irc_pix_t         o_pix,
  input wire logic             o_valid,
  input wire logic [DIM_W-1:0] o_buf_cols,
  input wire logic [DIM_W-1:0] o_buf_rows,
  input wire logic             o_auto_window_follow
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic        acc = psel && penable;
  wire logic        cfg = paddr inside {A_COLS, A_ROWS, A_XSTART, A_YSTART};
  logic [DIM_W-1:0] cnt_ff;
  logic             run_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst || (o_valid && o_pix.eol)) begin
      cnt_ff <= '0;
    end else if (o_valid) begin
      cnt_ff <= cnt_ff + 17'h0_0001;
    end
  end
  // Run is tracked from accepted writes, since the checker cannot see the register.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_ff <= 1'b0;
    end else if (acc && pwrite && !pslverr && paddr == A_CTRL) begin
      run_ff <= pwdata[B_RUN];
    end
  end
  a_row_len: assert property (o_valid && o_pix.eol |-> cnt_ff == o_buf_cols - 17'h0_0001)
    else $error("row length differs from window width");
  a_pad_valid: assert property (!o_ready |-> o_valid)
    else $error("padding cycle without output pixel");
  // The last padding pixel leaves the output register in the cycle in which ready returns.
  a_pad_end: assert property ($rose(o_ready) |-> o_valid && o_pix.eol)
    else $error("padding ended before a full row");
  a_valid_cause: assert property (o_valid |-> $past(i_valid && o_ready) || $past(!o_ready))
    else $error("output pixel without cause");
  a_err_keep: assert property (acc && pwrite && pslverr && paddr == A_COLS |=> $stable(o_buf_cols))
    else $error("refused write changed the width");
  a_err_phase: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  a_unmapped: assert property (acc && paddr > A_BUF_ROWS |-> pslverr)
    else $error("unmapped access not refused");
  a_busy_refuse: assert property (acc && pwrite && cfg && run_ff |-> pslverr)
    else $error("window write accepted while running");
  a_buf_cause: assert property ($changed(o_buf_rows) |-> $past(acc && pwrite && paddr == A_ROWS))
    else $error("buffer rows changed without a write");
  c_row: cover property (o_valid && o_pix.eol);
  c_pad: cover property (!o_ready);
  c_err: cover property (acc && pslverr);
endmodule
bind irc_crop irc_crop_monitor #(
  .DRAM_PIXELS(DRAM_PIXELS)
) u_mon (
  .i_clk               (i_clk),
  .i_rst               (i_rst),
  .psel                (psel),
  .penable             (penable),
  .pwrite              (pwrite),
  .paddr               (paddr),
  .pwdata              (pwdata),
  .prdata              (prdata),
  .pready              (pready),
  .pslverr             (pslverr),
  .i_pix               (i_pix),
  .i_valid             (i_valid),
  .o_ready             (o_ready),
  .o_pix               (o_pix),
  .o_valid             (o_valid),
  .o_buf_cols          (o_buf_cols),
  .o_buf_rows          (o_buf_rows),
  .o_auto_window_follow(o_auto_window_follow)
);
`default_nettype wire

// ==== verif/irc_cam_model.sv ====
// Behavioural camera source: one frame of i_cols by i_rows pixels per go pulse.
// Assumes a pixel is taken on each edge with valid and ready high.
`default_nettype none
module irc_cam_model
  import irc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic       i_slow,
  input  wire logic [7:0] i_cols,
  input  wire logic [7:0] i_rows,
  input  wire logic       i_ready,
  output irc_pix_t        o_pix,
  output logic            o_valid,
  output logic            o_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] col_ff = 8'h00;
  logic [7:0] row_ff = 8'h00;
  irc_pix_t   pix_ff = '0;
  logic       vld_ff = 1'b0;
  logic       busy_ff = 1'b0;
  wire logic       lastc = (col_ff == i_cols - 8'h01);
  wire logic [7:0] nc = lastc ? 8'h00 : col_ff + 8'h01;
  wire logic [7:0] nr = lastc ? row_ff + 8'h01 : row_ff;
  assign o_pix = pix_ff;
  assign o_valid = vld_ff;
  assign o_busy = busy_ff;
  function automatic irc_pix_t px(input logic [7:0] c, input logic [7:0] r);
    return '{data: {r, c}, sof: (c == 8'h00 && r == 8'h00), eol: (c == i_cols - 8'h01)};
  endfunction
  // Idle data is inverted junk, so a sink that ignores valid shows up at once.
  always @(posedge i_clk) begin
    if (!busy_ff) begin
      vld_ff <= 1'b0;
      pix_ff <= ~pix_ff;
      if (i_go) begin
        busy_ff <= 1'b1;
        col_ff <= 8'h00;
        row_ff <= 8'h00;
      end
    end else if (!vld_ff) begin
      vld_ff <= 1'b1;
      pix_ff <= px(col_ff, row_ff);
    end else if (i_ready) begin
      col_ff <= nc;
      row_ff <= nr;
      if (lastc && row_ff == i_rows - 8'h01) begin
        busy_ff <= 1'b0;
        vld_ff <= 1'b0;
      end else begin
        vld_ff <= !i_slow;
        pix_ff <= i_slow ? ~px(nc, nr) : px(nc, nr);
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/image_roi_crop_bench.sv ====
// Self-checking bench for the cropping stage: APB master, camera model and DMA sink.
// Assumes a 125 MHz clock and a small DRAM size so the mirror limit can be reached.
`default_nettype none
module image_roi_crop_bench
  import irc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic             i_clk = 1'b0;
  logic             i_rst = 1'b1;
  logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, slow = 1'b0;
  logic [7:0]       paddr = 8'h00, cam_cols = 8'h00, cam_rows = 8'h00;
  logic [31:0]      pwdata = 32'h0000_0000, prdata;
  logic             pready, pslverr, o_ready, o_valid, i_valid, follow, cam_busy;
  irc_pix_t         i_pix, o_pix;
  logic [DIM_W-1:0] buf_cols, buf_rows;
  int               fails = 0, check_count = 0, cyc = 0;
  irc_pix_t         got_q[$];
  irc_crop #(.DRAM_PIXELS(64'h0000_0000_0000_0100)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_pix(i_pix),
    .i_valid(i_valid), .o_ready(o_ready), .o_pix(o_pix), .o_valid(o_valid), .o_buf_cols(buf_cols),
    .o_buf_rows(buf_rows), .o_auto_window_follow(follow));
  irc_cam_model cam (.i_clk(i_clk), .i_go(go), .i_slow(slow), .i_cols(cam_cols), .i_rows(cam_rows),
    .i_ready(o_ready), .o_pix(i_pix), .o_valid(i_valid), .o_busy(cam_busy));
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (o_valid === 1'b1) got_q.push_back(o_pix);
    if (cyc > 6000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk(32'(e), 32'(ee));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, x);
  endtask
  // Every window row from y to y+h-1 is expected; callers keep them inside the camera frame, matching the truncation choice.
  task automatic frame(input logic [7:0] cc, input logic [7:0] cr, input logic sl,
                       input int x, input int y, input int w, input int h);
    int n;
    irc_pix_t e;
    n = 0;
    got_q.delete();
    cam_cols <= cc;
    cam_rows <= cr;
    slow <= sl;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    do @(posedge i_clk); while (cam_busy === 1'b1);
    repeat (2) @(posedge i_clk);
    while (o_valid !== 1'b0 || o_ready !== 1'b1) @(posedge i_clk);
    for (int r = y; r < y + h; r++) begin
      for (int c = x; c < x + w; c++) begin
        e.data = (c < cc) ? {r[7:0], c[7:0]} : 16'h0000;
        e.sof = (n == 0);
        e.eol = (c == x + w - 1);
        chk((n < got_q.size()) ? 32'(got_q[n]) : 32'hFFFF_FFFF, 32'(e));
        n++;
      end
    end
    chk(32'(got_q.size()), 32'(n));
    $display("test frame done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(A_COLS, 32'h0000_0400);
    rd(A_ROWS, 32'h0000_0400);
    rd(A_XSTART, 32'h0000_0000);
    rd(A_YSTART, 32'h0000_0000);
    chk(32'(buf_cols), 32'h0000_0400);
    wr(A_COLS, 32'h0000_0020, 1'b1);
    wr(A_COLS, 32'h0000_0050, 1'b1);
    wr(A_COLS, 32'h0000_8020, 1'b1);
    wr(A_ROWS, 32'h0000_0001, 1'b1);
    wr(A_XSTART, 32'h0000_0010, 1'b1);
    wr(A_YSTART, 32'h0001_0000, 1'b1);
    wr(A_COLS, 32'h0000_0040, 1'b0);
    wr(A_XSTART, 32'h0000_7FC0, 1'b0);
    wr(A_COLS, 32'h0000_0060, 1'b1);
    rd(A_COLS, 32'h0000_0040);
    rd(A_STATUS, 32'h0000_0001);
    wr(A_STATUS, 32'h0000_0001, 1'b0);
    rd(A_STATUS, 32'h0000_0000);
    wr(A_ROWS, 32'h0001_0000, 1'b0);
    wr(A_YSTART, 32'h0000_0001, 1'b1);
    wr(A_ROWS, 32'h0000_0002, 1'b0);
    wr(A_YSTART, 32'h0000_FFFF, 1'b1);
    wr(A_YSTART, 32'h0000_FFFE, 1'b0);
    wr(8'h28, 32'h0000_0001, 1'b1);
    rd(8'h28, 32'h0000_0000);
    $display("test limits done");
    wr(A_XSTART, 32'h0000_0000, 1'b0);
    wr(A_YSTART, 32'h0000_0000, 1'b0);
    wr(A_FF_COLS, 32'h0000_0040, 1'b0);
    wr(A_FF_ROWS, 32'h0000_0004, 1'b0);
    wr(A_ROWS, 32'h0000_0004, 1'b0);
    wr(A_CTRL, 32'h0000_0004, 1'b1);
    wr(A_ROWS, 32'h0000_0002, 1'b0);
    wr(A_FF_ROWS, 32'h0000_0002, 1'b0);
    wr(A_CTRL, 32'h0000_0004, 1'b0);
    wr(A_YSTART, 32'h0000_0001, 1'b1);
    wr(A_CTRL, 32'h0000_0002, 1'b0);
    wr(A_XSTART, 32'h0000_0020, 1'b1);
    wr(A_CTRL, 32'h0000_0000, 1'b0);
    wr(A_XSTART, 32'h0000_0020, 1'b0);
    wr(A_YSTART, 32'h0000_0001, 1'b0);
    rd(A_BUF_ROWS, 32'h0000_0002);
    rd(A_FF_ROWS, 32'h0000_0002);
    $display("test mirror done");
    // Following stays off here, so the host may still own width and height.
    wr(A_CTRL, 32'h0000_0001, 1'b0);
    chk(32'(follow), 32'h0000_0000);
    frame(8'h80, 8'h04, 1'b0, 32, 1, 64, 2);
    frame(8'h40, 8'h03, 1'b1, 32, 1, 64, 2);
    wr(A_COLS, 32'h0000_0060, 1'b1);
    chk(32'(buf_cols), 32'h0000_0040);
    wr(A_CTRL, 32'h0000_0000, 1'b0);
    rd(A_STATUS, 32'h0000_0003);
    frame(8'h80, 8'h04, 1'b0, 32, 1, 64, 0);
    rd(A_STATUS, 32'h0000_0001);
    wr(A_COLS, 32'h0000_0060, 1'b0);
    rd(A_BUF_COLS, 32'h0000_0060);
    // With following on, the host copies the camera frame size into the window before it starts.
    wr(A_CTRL, 32'h0000_0008, 1'b0);
    chk(32'(follow), 32'h0000_0001);
    wr(A_COLS, 32'h0000_0080, 1'b0);
    wr(A_ROWS, 32'h0000_0004, 1'b0);
    wr(A_CTRL, 32'h0000_0009, 1'b0);
    rd(A_CTRL, 32'h0000_0009);
    chk(32'(buf_rows), 32'h0000_0004);
    frame(8'h80, 8'h04, 1'b0, 32, 1, 128, 3);
    stop_test();
  end
endmodule
`default_nettype wire
